//--- logic/bpas_port.v
// eight-pin bidirectional port with analog select and an input-only pin
// assumes software strobes come from logic on ref_clk; pads are asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "bpas_defs.vh"

module bpas_port #(
    parameter WIDTH = `BPAS_PORT_WIDTH,
    parameter SLOTS = `BPAS_SLOTS
) (
    // clock and reset
    input  wire                   ref_clk,
    input  wire                   rstn,
    // port data writes, read-modify-write
    input  wire                   port_a_data_wr,
    input  wire [WIDTH-1:0]       port_a_data_wdata,
    input  wire [WIDTH-1:0]       port_a_data_wmask,
    // direct output latch writes
    input  wire                   port_a_output_latch_wr,
    input  wire [WIDTH-1:0]       port_a_output_latch_wdata,
    // direction and analog select writes
    input  wire                   port_a_direction_wr,
    input  wire [WIDTH-1:0]       port_a_direction_wdata,
    input  wire                   port_a_analog_select_wr,
    input  wire [WIDTH-1:0]       port_a_analog_select_wdata,
    // register read-back
    output reg  [WIDTH-1:0]       port_a_data,
    output reg  [WIDTH-1:0]       port_a_direction,
    output reg  [WIDTH-1:0]       port_a_output_latch,
    output reg  [WIDTH-1:0]       port_a_analog_select,
    // peripheral functions, slot k of pin i at bit i*SLOTS+k
    input  wire [WIDTH*SLOTS-1:0] fn_en,
    input  wire [WIDTH*SLOTS-1:0] fn_out,
    output reg  [WIDTH-1:0]       fn_owned,
    // port A pads
    input  wire [WIDTH-1:0]       pad_a_in,
    output reg  [WIDTH-1:0]       pad_a_out,
    output reg  [WIDTH-1:0]       pad_a_oe_n,
    // port E input-only pad and master clear
    input  wire                   port_e_input_pin,
    input  wire                   master_clear_enable,
    output reg  [7:0]             port_e_data,
    output reg  [7:0]             port_e_direction,
    output reg                    master_clear_n
);

    // ----------------------------------------------------------------
    // pad synchronisers
    // ----------------------------------------------------------------
    reg  [WIDTH-1:0] pad_a_meta;
    reg  [WIDTH-1:0] pad_a_sync;
    reg              port_e_meta;
    reg              port_e_sync;
    // port E flops reset high so master clear stays released while they refill

    always @(posedge ref_clk) begin
        if (!rstn) begin
            pad_a_meta  <= `BPAS_BYTE_ZERO;
            pad_a_sync  <= `BPAS_BYTE_ZERO;
            port_e_meta <= 1'b1;
            port_e_sync <= 1'b1;
        end else begin
            pad_a_meta  <= pad_a_in;
            pad_a_sync  <= pad_a_meta;
            port_e_meta <= port_e_input_pin;
            port_e_sync <= port_e_meta;
        end
    end

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    reg  [WIDTH-1:0] dir;
    reg  [WIDTH-1:0] latch;
    reg  [WIDTH-1:0] ansel;
    wire [WIDTH-1:0] pin_read;
    wire [WIDTH-1:0] input_only_mask;
    wire [WIDTH-1:0] next_latch_rmw;
    reg  [WIDTH-1:0] next_latch;

    assign input_only_mask = {{(WIDTH-1){1'b0}}, 1'b1} << `BPAS_INPUT_ONLY_PIN;
    // analog pins read 0, which is also what the merge sees
    assign pin_read       = pad_a_sync & ~ansel;
    // the merge uses pin levels, not the latch, so an analog output pin
    // loses its latch bit on any port write whose mask leaves that bit out
    assign next_latch_rmw = (pin_read & ~port_a_data_wmask)
                          | (port_a_data_wdata & port_a_data_wmask);

    // a direct latch write wins over a port write in the same cycle, and
    // the lost port write leaves no trace
    always @* begin
        next_latch = latch;
        if (port_a_output_latch_wr) begin
            next_latch = port_a_output_latch_wdata;
        end else if (port_a_data_wr) begin
            next_latch = next_latch_rmw;
        end
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            dir   <= `BPAS_DIR_RESET;
            latch <= `BPAS_LATCH_RESET;
            ansel <= `BPAS_ANSEL_RESET;
        end else begin
            if (port_a_direction_wr) begin
                dir <= port_a_direction_wdata | input_only_mask;
            end
            if (port_a_analog_select_wr) begin
                ansel <= port_a_analog_select_wdata;
            end
            latch <= next_latch;
        end
    end

    // ----------------------------------------------------------------
    // per-pin output arbitration
    // ----------------------------------------------------------------
    localparam [`BPAS_FN_WIDTH-1:0] SLOT_USED   = `BPAS_SLOT_USED;
    localparam [`BPAS_FN_WIDTH-1:0] SLOT_DRIVES = `BPAS_SLOT_DRIVES;

    wire [WIDTH-1:0] mux_en;
    wire [WIDTH-1:0] mux_val;
    wire [WIDTH-1:0] mux_owned;
    wire [WIDTH-1:0] port_drive;

    // ansel is left out on purpose: analog mode never cuts the driver
    assign port_drive = ~dir & ~input_only_mask;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
            bpas_pin_mux #(
                .SLOTS  (SLOTS),
                .USED   (SLOT_USED[i*SLOTS +: SLOTS]),
                .DRIVES (SLOT_DRIVES[i*SLOTS +: SLOTS])
            ) u_mux (
                .fn_en      (fn_en[i*SLOTS +: SLOTS]),
                .fn_out     (fn_out[i*SLOTS +: SLOTS]),
                .port_drive (port_drive[i]),
                .port_val   (latch[i]),
                .drv_en     (mux_en[i]),
                .drv_val    (mux_val[i]),
                .fn_owned   (mux_owned[i])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // registered pad drive
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rstn) begin
            pad_a_out  <= `BPAS_BYTE_ZERO;
            pad_a_oe_n <= `BPAS_BYTE_ONES;
            fn_owned   <= `BPAS_BYTE_ZERO;
        end else begin
            pad_a_out  <= mux_val;
            pad_a_oe_n <= ~mux_en;
            fn_owned   <= mux_owned;
        end
    end

    // ----------------------------------------------------------------
    // registered read-back
    // ----------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (!rstn) begin
            port_a_data          <= `BPAS_BYTE_ZERO;
            port_a_direction     <= `BPAS_DIR_RESET;
            port_a_output_latch  <= `BPAS_LATCH_RESET;
            port_a_analog_select <= `BPAS_ANSEL_RESET;
        end else begin
            port_a_data          <= pin_read;
            port_a_direction     <= dir | input_only_mask;
            port_a_output_latch  <= latch;
            port_a_analog_select <= ansel;
        end
    end

    // ----------------------------------------------------------------
    // port E input-only pin and master clear
    // ----------------------------------------------------------------
    reg  [7:0] next_port_e_data;
    reg        next_master_clear_n;

    // the fuse is a static configuration bit, so it is read without a synchroniser
    always @* begin
        next_port_e_data    = port_e_sync ? `BPAS_PORT_E_MASK : `BPAS_BYTE_ZERO;
        next_master_clear_n = master_clear_enable ? port_e_sync : 1'b1;
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            port_e_data      <= `BPAS_BYTE_ZERO;
            port_e_direction <= `BPAS_PORT_E_DIR_READ;
            master_clear_n   <= 1'b1;
        end else begin
            port_e_data      <= next_port_e_data;
            port_e_direction <= `BPAS_PORT_E_DIR_READ;
            // input only: nothing in the block ever drives this pad
            master_clear_n   <= next_master_clear_n;
        end
    end

endmodule // bpas_port

`default_nettype wire

//--- logic/bpas_defs.vh
// constants for the eight-pin bidirectional port with analog select
// assumes inclusion by bare name from the port module; the pin mux does not include it
`ifndef BPAS_DEFS_VH
`define BPAS_DEFS_VH

// ----------------------------------------------------------------
// widths and pin positions
// ----------------------------------------------------------------
`define BPAS_PORT_WIDTH      8
`define BPAS_SLOTS           3
`define BPAS_FN_WIDTH        24
`define BPAS_INPUT_ONLY_PIN  3
`define BPAS_PORT_E_PIN      3

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define BPAS_DIR_RESET       8'hFF
`define BPAS_LATCH_RESET     8'h00
`define BPAS_ANSEL_RESET     8'hFF
`define BPAS_BYTE_ZERO       8'h00
`define BPAS_BYTE_ONES       8'hFF
`define BPAS_PORT_E_DIR_READ 8'h08
`define BPAS_PORT_E_MASK     8'h08

// ----------------------------------------------------------------
// peripheral slot map: slot k of pin i sits at bit i*3+k, slot 0 highest
// pin0 seg | pin1 seg | pin2 com | pin3 vref,com,seg | pin4 seg,timer clk
// pin5 seg | pin6 clock out,seg | pin7 clock in,seg
// ----------------------------------------------------------------
`define BPAS_SLOT_USED       24'h6CBE49
// slots that drive the pin; vref, timer clock and clock input only claim it
`define BPAS_SLOT_DRIVES     24'h4C9C49

`endif

//--- logic/bpas_pin_mux.v
// per-pin output arbiter: picks the highest-priority enabled function
// assumes slot 0 is the highest priority and the port driver the lowest
`timescale 1ns/1ps
`default_nettype none

module bpas_pin_mux #(
    parameter             SLOTS  = 3,
    parameter [SLOTS-1:0] USED   = 3'h1,
    parameter [SLOTS-1:0] DRIVES = 3'h1
) (
    // peripheral functions
    input  wire [SLOTS-1:0] fn_en,
    input  wire [SLOTS-1:0] fn_out,
    // port latch path
    input  wire             port_drive,
    input  wire             port_val,
    // resolved pin control
    output reg              drv_en,
    output reg              drv_val,
    output reg              fn_owned
);

    integer k;

    // ----------------------------------------------------------------
    // priority walk, lowest first so the highest enabled slot wins
    // ----------------------------------------------------------------
    always @* begin
        drv_en   = port_drive;
        drv_val  = port_val;
        fn_owned = 1'b0;
        for (k = SLOTS - 1; k >= 0; k = k - 1) begin
            if (USED[k] && fn_en[k]) begin
                drv_en   = DRIVES[k];
                drv_val  = fn_out[k];
                fn_owned = 1'b1;
            end
        end
    end

endmodule // bpas_pin_mux

`default_nettype wire

//--- tb/bpas_port_properties.sv
// checker: pad drive, read-back and port E relations of bpas_port
// assumes one ref_clk domain and synchronous active-low rstn
`timescale 1ns/1ps
`default_nettype none
module bpas_port_properties (
    input wire logic        ref_clk,
    input wire logic        rstn,
    input wire logic        port_a_output_latch_wr,
    input wire logic [7:0]  port_a_output_latch_wdata,
    input wire logic [7:0]  port_a_data,
    input wire logic [7:0]  port_a_direction,
    input wire logic [7:0]  port_a_output_latch,
    input wire logic [7:0]  port_a_analog_select,
    input wire logic [23:0] fn_en,
    input wire logic [23:0] fn_out,
    input wire logic [7:0]  fn_owned,
    input wire logic [7:0]  pad_a_out,
    input wire logic [7:0]  pad_a_oe_n,
    input wire logic        master_clear_enable,
    input wire logic [7:0]  port_e_data,
    input wire logic [7:0]  port_e_direction,
    input wire logic        master_clear_n
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_dir_bit3_one: assert property (port_a_direction[3] == 1'b1)
        else $error("direction bit 3 read 0");
    a_porte_dir_fixed: assert property (port_e_direction == 8'h08)
        else $error("port e direction wrong");
    a_porte_data_zero: assert property ((port_e_data & 8'hF7) == 8'h00)
        else $error("port e spare bits set");
    a_clear_tracks_pin: assert property (master_clear_enable |=>
        master_clear_n == port_e_data[3]) else $error("master clear off pin");
    a_clear_fuse_off: assert property (!master_clear_enable |=> master_clear_n)
        else $error("master clear asserted with fuse off");
    a_analog_reads_zero: assert property ($stable(port_a_analog_select) |->
        (port_a_data & port_a_analog_select) == 8'h00) else $error("analog pin read 1");
    a_oe_follows_dir: assert property ($stable(port_a_direction) && $stable(fn_owned) |->
        ((pad_a_oe_n ^ port_a_direction) & ~fn_owned) == 8'h00) else $error("oe off dir");
    a_out_follows_latch: assert property ($stable(port_a_output_latch) && $stable(fn_owned) |->
        ((pad_a_out ^ port_a_output_latch) & ~pad_a_oe_n & ~fn_owned) == 8'h00)
        else $error("pad out off latch");
    a_latch_write_lands: assert property (port_a_output_latch_wr |-> ##2
        port_a_output_latch == $past(port_a_output_latch_wdata, 2)) else $error("latch lost");
    a_pin0_seg_wins: assert property (fn_en[0] |=> fn_owned[0] && !pad_a_oe_n[0] &&
        pad_a_out[0] == $past(fn_out[0])) else $error("pin 0 segment lost");
endmodule // bpas_port_properties
bind bpas_port bpas_port_properties u_props (.ref_clk(ref_clk), .rstn(rstn),
    .port_a_output_latch_wr(port_a_output_latch_wr), .port_a_data(port_a_data),
    .port_a_output_latch_wdata(port_a_output_latch_wdata), .fn_en(fn_en), .fn_out(fn_out),
    .port_a_direction(port_a_direction), .port_a_output_latch(port_a_output_latch),
    .port_a_analog_select(port_a_analog_select), .fn_owned(fn_owned), .pad_a_out(pad_a_out),
    .pad_a_oe_n(pad_a_oe_n), .master_clear_enable(master_clear_enable),
    .port_e_data(port_e_data), .port_e_direction(port_e_direction),
    .master_clear_n(master_clear_n));
`default_nettype wire

//--- tb/bpas_board.sv
// board model: external levels on the port A and port E pads
// assumes pad_a_oe_n low means the device drives that pad
`timescale 1ns/1ps
`default_nettype none
module bpas_board (
    input  wire logic [7:0] pad_a_out,
    input  wire logic [7:0] pad_a_oe_n,
    input  wire logic [7:0] ext_level,
    input  wire logic       ext_e,
    output wire logic [7:0] pad_a_in,
    output wire logic       pad_e
);
    // the board yields wherever the device driver is on, so no contention
    assign pad_a_in = (pad_a_out & ~pad_a_oe_n) | (ext_level & pad_a_oe_n);
    assign pad_e    = ext_e;
endmodule // bpas_board
`default_nettype wire

//--- tb/bpas_port_tb_top.sv
// self-checking bench for bpas_port with a board model on the pads
// assumes 100 MHz ref_clk; inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module bpas_port_tb_top;
    logic        ref_clk, rstn, dwr, lwr, twr, swr, ext_e, mc_en;
    logic [7:0]  wdata, wmask, ext_level;
    logic [23:0] fn_en, fn_out;
    wire  [7:0]  a_data, a_dir, a_lat, a_sel, owned, p_out, p_oen, p_in, e_data, e_dir;
    wire         pad_e, clr_n;
    int          mismatches, n_tests;
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    bpas_port dut (.ref_clk(ref_clk), .rstn(rstn), .port_a_data_wr(dwr),
        .port_a_data_wdata(wdata), .port_a_data_wmask(wmask), .port_a_output_latch_wr(lwr),
        .port_a_output_latch_wdata(wdata), .port_a_direction_wr(twr),
        .port_a_direction_wdata(wdata), .port_a_analog_select_wr(swr),
        .port_a_analog_select_wdata(wdata), .port_a_data(a_data), .port_a_direction(a_dir),
        .port_a_output_latch(a_lat), .port_a_analog_select(a_sel), .fn_en(fn_en),
        .fn_out(fn_out), .fn_owned(owned), .pad_a_in(p_in), .pad_a_out(p_out),
        .pad_a_oe_n(p_oen), .port_e_input_pin(pad_e), .master_clear_enable(mc_en),
        .port_e_data(e_data), .port_e_direction(e_dir), .master_clear_n(clr_n));
    bpas_board board (.pad_a_out(p_out), .pad_a_oe_n(p_oen), .ext_level(ext_level),
        .ext_e(ext_e), .pad_a_in(p_in), .pad_e(pad_e));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // sel 0 port write, 1 latch, 2 direction, 3 analog select; waits out the pad syncs
    task automatic wr(input logic [1:0] sel, input logic [7:0] d, input logic [7:0] m);
        wdata = d;
        wmask = m;
        {dwr, lwr, twr, swr} = 4'h8 >> sel;
        @(negedge ref_clk);
        {dwr, lwr, twr, swr} = 4'h0;
        repeat (6) @(negedge ref_clk);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        {rstn, dwr, lwr, twr, swr, wdata, wmask, fn_en, fn_out} = '0;
        {mismatches, n_tests} = '0;
        ext_level = 8'hFF;
        ext_e = 1'b1;
        mc_en = 1'b1;
        repeat (4) @(negedge ref_clk);
        rstn = 1'b1;
        chk("dir", a_dir, 8'hFF);
        chk("ansel", a_sel, 8'hFF);
        chk("latch", a_lat, 8'h00);
        wr(2, 8'h00, 8'h00);
        chk("dir", a_dir, 8'h08);
        chk("oe", p_oen, 8'h08);
        wr(1, 8'hA5, 8'h00);
        chk("pad", p_out & ~p_oen, 8'hA5 & 8'hF7);
        chk("data", a_data, 8'h00);
        $display("test drive in analog mode done");
        wr(3, 8'h00, 8'h00);
        chk("data", a_data, (8'hA5 & 8'hF7) | 8'h08);
        ext_level = 8'h3C;
        wr(2, 8'hFF, 8'h00);
        chk("data", a_data, 8'h3C);
        wr(0, 8'h05, 8'h0F);
        chk("latch", a_lat, (8'h3C & 8'hF0) | 8'h05);
        chk("data", a_data, 8'h3C);
        wr(3, 8'hF0, 8'h00);
        chk("data", a_data, 8'h3C & 8'h0F);
        wr(0, 8'h00, 8'h00);
        chk("latch", a_lat, 8'h0C);
        $display("test read-modify-write done");
        wr(2, 8'h00, 8'h00);
        // pin0 seg, pin3 vref over com, pin4 timer clk, pin6 clock out over seg, unused pin2 slot
        fn_out = 24'h080481;
        fn_en = 24'h0C2681;
        repeat (3) @(negedge ref_clk);
        chk("owned", owned, 8'h59);
        chk("oe", p_oen, 8'h18);
        chk("pad", p_out & ~p_oen, 8'h05);
        fn_en = 24'h000000;
        $display("test priority done");
        ext_e = 1'b0;
        repeat (4) @(negedge ref_clk);
        chk("port e", e_data, 8'h00);
        chk("master clear", {7'h00, clr_n}, 8'h00);
        chk("port e dir", e_dir, 8'h08);
        mc_en = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk("master clear", {7'h00, clr_n}, 8'h01);
        chk("port e", e_data, 8'h00);
        mc_en = 1'b1;
        ext_e = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("port e", e_data, 8'h08);
        chk("master clear", {7'h00, clr_n}, 8'h01);
        rstn = 1'b0;
        repeat (4) @(negedge ref_clk);
        rstn = 1'b1;
        chk("ansel", a_sel, 8'hFF);
        chk("dir", a_dir, 8'hFF);
        $display("test port e and reset done");
        give_verdict();
    end
endmodule // bpas_port_tb_top
`default_nettype wire
